// File: hdl/power_mode_control.sv
`timescale 1ns/1ps
// Behaviour
// - Writing power-down bit enters power-down
// - Power-down stops CPU and divided clock
// - Power-down ends on reset or interrupt
// - Wake-select governs interrupt release of both modes
// - Wake-select zero: only enabled interrupts release
// - Wake-select one: any flagged interrupt releases
// - Wake-select cleared only by software
// - Hard power-down enable bit arms function
// - Armed, power-fail fall enters hard power-down
// - Hard power-down left only by reset
// - Baud bit acts in serial modes 1-3
// - Baud bit zero halves serial clock
// - Baud bit one keeps serial clock full
module power_mode_control
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [power_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [power_mode_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [power_mode_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [power_mode_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt controller view
    input wire logic [power_mode_pkg::IRQ_N-1:0] interrupt_flags,
    input wire logic [power_mode_pkg::IRQ_N-1:0] interrupt_enable_reg,
    // Power-fail pin
    input wire logic power_fail_input,
    // Serial port clocking
    input wire logic timer1_carry,
    input wire logic [1:0] serial_mode,
    output logic serial_clock_tick,
    // Clock gating
    output logic cpu_run,
    output logic periph_clock_run,
    output logic oscillator_run
);
    import power_mode_pkg::*;

    // ============================================================
    // Write channel
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [7:0] control;
    power_state_t state;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_got || aw_take;
    wire w_have = w_got || w_take;
    wire do_write = aw_have && w_have;
    wire [ADDR_W-1:0] wr_addr = aw_got ? aw_addr : s_axi_awaddr;
    wire [7:0] wr_byte = w_got ? w_byte : s_axi_wdata[7:0];
    // Lane 0 carries the only byte of the register
    wire wr_lane0 = w_got ? w_lane0 : s_axi_wstrb[0];
    wire wr_hit_ctl = wr_addr == OFS_CONTROL;
    wire wr_hit_st = wr_addr == OFS_STATUS;
    // Unmapped addresses answer with an error and change nothing
    wire wr_ok = wr_hit_ctl || wr_hit_st;
    wire ctl_write = do_write && wr_hit_ctl && wr_lane0;
    wire next_aw_got = aw_have && !do_write;
    wire next_w_got = w_have && !do_write;
    wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

    // Half of a write may arrive first; it is parked until its partner
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (aw_take)
                aw_addr <= s_axi_awaddr;
            if (w_take)
            begin
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // Readies stay low while a response waits, so one write at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !next_aw_got && !next_bvalid;
            s_axi_wready <= !next_w_got && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bresp <= RESP_OKAY;
        else if (do_write)
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // ============================================================
    // Read channel
    logic [2:0] fail_sync;
    logic fail_level;

    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_hit_ctl = s_axi_araddr == OFS_CONTROL;
    wire rd_hit_st = s_axi_araddr == OFS_STATUS;
    wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
    // Bit 4 has no storage behind it and always reads one
    wire [7:0] ctl_view = control | RESERVED_ONES;
    wire [7:0] st_view = 8'h00
        | (8'(state) << ST_STATE_LSB)
        | (8'(fail_level) << ST_PIN);
    wire [7:0] rd_byte = rd_hit_ctl ? ctl_view
                       : rd_hit_st ? st_view : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end
        else
        begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // Read data is captured once at the address handshake and then
    // held, so it stands unchanged for as long as rvalid waits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= (rd_hit_ctl || rd_hit_st)
                         ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ============================================================
    // Power-fail pin filter
    // A level counts only once the second and third stages agree,
    // so a single-cycle glitch cannot trigger hard power-down
    wire next_fail_level = (fail_sync[1] == fail_sync[2])
                         ? fail_sync[2] : fail_level;
    wire fail_fall = fail_level && !next_fail_level;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fail_sync <= 3'h7;
        else
            fail_sync <= {fail_sync[1:0], power_fail_input};
    end

    // Level resets high, so a pin held low through reset reads as a fall once it reaches the third stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fail_level <= 1'b1;
        else
            fail_level <= next_fail_level;
    end

    // ============================================================
    // Power state machine
    wire [IRQ_N-1:0] enabled_irq = interrupt_flags & interrupt_enable_reg;
    wire wake_any = |interrupt_flags;
    wire wake_enabled = |enabled_irq;
    wire wake = control[BIT_WAKE_SEL] ? wake_any : wake_enabled;
    wire low_power = (state == ST_IDLE) || (state == ST_PDOWN);
    wire wake_now = low_power && wake;
    wire hard_trip = control[BIT_HARD_EN] && fail_fall;
    power_state_t next_state;

    // Entry only from run; a power-down request outranks idle
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
                if (ctl_write && wr_byte[BIT_PDOWN])
                    next_state = ST_PDOWN;
                else if (ctl_write && wr_byte[BIT_IDLE])
                    next_state = ST_IDLE;
            ST_IDLE,
            ST_PDOWN:
                if (wake)
                    next_state = ST_RUN;
            ST_HARD:
                next_state = ST_HARD;
            default:
                next_state = ST_RUN;
        endcase
        // Hard power-down outranks every other move; only reset leaves it
        if (hard_trip)
            next_state = ST_HARD;
    end

    // Mode request bits drop on wake; a write in the same cycle wins.
    // The wake-select bit is never touched by hardware.
    logic [7:0] next_control;

    always_comb
    begin
        next_control = control;
        if (wake_now)
        begin
            next_control[BIT_IDLE] = 1'b0;
            next_control[BIT_PDOWN] = 1'b0;
        end
        if (ctl_write)
            next_control = wr_byte & ~RESERVED_ONES;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            control <= CONTROL_RESET;
        else
            control <= next_control;
    end

    // ============================================================
    // Clock gating outputs
    // Idle keeps peripherals and interrupt logic alive so they can wake
    wire next_cpu_run = next_state == ST_RUN;
    wire next_periph_run = (next_state == ST_RUN)
                        || (next_state == ST_IDLE);
    wire next_osc_run = next_state != ST_HARD;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cpu_run <= 1'b1;
        else
            cpu_run <= next_cpu_run;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            periph_clock_run <= 1'b1;
        else
            periph_clock_run <= next_periph_run;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            oscillator_run <= 1'b1;
        else
            oscillator_run <= next_osc_run;
    end

    // ============================================================
    // Serial clock divider
    // Mode 0 ticks on every timer carry, so the baud bit is ignored there
    logic half_phase;

    wire timer_clocked = serial_mode != SERIAL_MODE_0;
    wire halve = timer_clocked && !control[BIT_BAUD];
    wire carry_live = timer1_carry && periph_clock_run;
    wire next_tick = carry_live && (!halve || half_phase);

    // The phase toggles in every mode, so a halved run drops its first carry only after an even count of earlier carries
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            half_phase <= 1'b0;
        else if (carry_live)
            half_phase <= !half_phase;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            serial_clock_tick <= 1'b0;
        else
            serial_clock_tick <= next_tick;
    end

endmodule // power_mode_control

// File: hdl/power_mode_pkg.sv
package power_mode_pkg;

    // ============================================================
    // Bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ============================================================
    // Control register fields
    localparam int BIT_IDLE = 0;
    localparam int BIT_PDOWN = 1;
    localparam int BIT_FLAG_A = 2;
    localparam int BIT_FLAG_B = 3;
    localparam int BIT_RESERVED = 4;
    localparam int BIT_WAKE_SEL = 5;
    localparam int BIT_HARD_EN = 6;
    localparam int BIT_BAUD = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RESERVED_ONES = 8'h10;

    // ============================================================
    // Status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_PIN = 2;

    // ============================================================
    // Interrupt sources and serial modes
    localparam int IRQ_N = 6;
    localparam logic [1:0] SERIAL_MODE_0 = 2'h0;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_IDLE = 2'b01,
        ST_PDOWN = 2'b10,
        ST_HARD = 2'b11
    } power_state_t;

endpackage

// File: tb/power_mode_props.sv
`timescale 1ns/1ps
module power_mode_props
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic [power_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [power_mode_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power side
    input wire logic [power_mode_pkg::IRQ_N-1:0] interrupt_flags,
    input wire logic [power_mode_pkg::IRQ_N-1:0] interrupt_enable_reg,
    input wire logic power_fail_input,
    input wire logic timer1_carry,
    input wire logic serial_clock_tick,
    input wire logic cpu_run,
    input wire logic periph_clock_run,
    input wire logic oscillator_run
);
    import power_mode_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ====================
    // Sequences
    sequence s_wr_ctl;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == OFS_CONTROL && s_axi_wstrb[0];
    endsequence
    // Quiet interrupts only, so an entry cannot be undone at once
    sequence s_enter(logic [1:0] req);
        s_wr_ctl ##0 s_axi_wdata[1:0] == req && cpu_run
            && interrupt_flags == '0;
    endsequence
    // ====================
    // Properties
    a_idle_entry: assert property (s_enter(2'h1) |-> ##[1:3]
        !cpu_run && periph_clock_run) else $error("idle entry wrong");
    a_pdown_entry: assert property (s_enter(2'h2) |-> ##[1:3]
        !cpu_run && !periph_clock_run) else $error("pdown entry wrong");
    a_pdown_halt: assert property (!periph_clock_run |-> !cpu_run)
        else $error("cpu runs with clocks stopped");
    a_wake_enabled: assert property (!cpu_run && oscillator_run
        && |(interrupt_flags & interrupt_enable_reg) |-> ##2 cpu_run)
        else $error("enabled interrupt did not wake");
    a_hard_off: assert property (!oscillator_run
        |-> !cpu_run && !periph_clock_run) else $error("hard mode leak");
    // The filter trips on the two pin samples taken three and four
    // edges before the oscillator gate is seen low
    a_hard_cause: assert property ($fell(oscillator_run)
        |-> !$past(power_fail_input, 3) && !$past(power_fail_input, 4))
        else $error("osc stop no fall");
    a_hard_stays: assert property (!oscillator_run
        |=> !oscillator_run) else $error("hard mode left");
    a_tick_cause: assert property (serial_clock_tick
        |-> $past(timer1_carry)) else $error("tick without carry");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("rvalid dropped");
endmodule // power_mode_props

bind power_mode_control power_mode_props u_props (.*);

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import power_mode_pkg::*;
    // ====================
    // Signals
    logic aclk = 1'h0, aresetn = 1'h0, timer1_carry = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic power_fail_input = 1'h1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, serial_mode = 2'h0;
    logic [IRQ_N-1:0] interrupt_flags = '0, interrupt_enable_reg = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, serial_clock_tick, cpu_run, periph_clock_run;
    logic oscillator_run;
    logic [31:0] rnd = 32'hb47aa264;
    int fails = 0, num_checks = 0, ticks = 0, mc = 0, ms = 0, t0 = 0;
    logic [1:0] rr;
    power_mode_control dut (.*);
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (serial_clock_tick === 1'h1) ticks++;
    // ====================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // A handshake that never completes ends the run as a failure
    task automatic lim(input int n);
        if (n >= 20)
        begin
            fails++;
            results();
        end
        cyc(2);
    endtask
    // Valid and payload are held until the edge that samples ready
    task automatic wr(input logic [3:0] a, input int v, input int er);
        int n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 20 && s_axi_bvalid !== 1'h1; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        lim(n);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 20 && s_axi_rvalid !== 1'h1; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        v = s_axi_rdata;
        rr = s_axi_rresp;
        lim(n);
    endtask
    // Compare status and gating outputs with the model state
    task automatic st();
        rd(OFS_STATUS, d);
        chk(d, {29'h0, power_fail_input, ms[1:0]});
        chk(cpu_run, ms == 0);
        chk(periph_clock_run, ms < 2);
        chk(oscillator_run, ms < 3);
    endtask
    task automatic rst();
        aresetn <= 1'h0;
        cyc(2);
        aresetn <= 1'h1;
        cyc(2);
        ms = 0;
        st();
    endtask
    // ====================
    // Sequence
    initial
    begin
        cyc(20);
        aresetn <= 1'h1;
        cyc(2);
        rd(OFS_CONTROL, d);
        chk(d, 32'h10);
        chk(rr, RESP_OKAY);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            wr(OFS_CONTROL, rnd & 32'h9c, RESP_OKAY);
            rd(OFS_CONTROL, d);
            chk(d, (rnd & 32'h8c) | 32'h10);
        end
        wr(4'h8, 32'h0, RESP_SLVERR);
        rd(4'h8, d);
        chk(d, 32'h0);
        chk(rr, RESP_SLVERR);
        for (int m = 1; m < 3; m++)
            for (int w = 0; w < 2; w++)
            begin
                mc = (w << 5) | m;
                wr(OFS_CONTROL, mc, RESP_OKAY);
                ms = m;
                cyc(3);
                st();
                rnd = lfsr(rnd);
                interrupt_flags <= 6'h1 << (rnd % IRQ_N);
                cyc(4);
                if (w) ms = 0;
                st();
                interrupt_enable_reg <= interrupt_flags;
                cyc(4);
                ms = 0;
                st();
                rd(OFS_CONTROL, d);
                chk(d, (mc & 32'h20) | 32'h10);
                {interrupt_flags, interrupt_enable_reg} <= '0;
            end
        wr(OFS_CONTROL, 32'h2, RESP_OKAY);
        cyc(3);
        rst();
        for (int k = 0; k < 8; k++)
        begin
            serial_mode <= k[1:0];
            wr(OFS_CONTROL, k[2] ? 32'h80 : 32'h0, RESP_OKAY);
            t0 = ticks;
            repeat (16)
            begin
                @(posedge aclk);
                timer1_carry <= ~timer1_carry;
            end
            cyc(3);
            chk(ticks - t0, (k[2] || k[1:0] == 2'h0) ? 8 : 4);
        end
        power_fail_input <= 1'h0;
        cyc(8);
        st();
        power_fail_input <= 1'h1;
        cyc(6);
        wr(OFS_CONTROL, 32'h40, RESP_OKAY);
        power_fail_input <= 1'h0;
        cyc(8);
        ms = 3;
        st();
        {interrupt_flags, interrupt_enable_reg} <= '1;
        cyc(6);
        st();
        {interrupt_flags, interrupt_enable_reg} <= '0;
        power_fail_input <= 1'h1;
        rst();
        results();
    end
endmodule // tb
